// ==== common/hpc_pkg.sv ====
// Package of the hub port configuration registers: offsets, fields, resets, carriers.
// Assumes a byte-wide register port driven by the EEPROM loader or the SMBus slave.
`default_nettype none

package hpc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] HPC_OFS_LINK_POWER = 8'h05;
	localparam logic [7:0] HPC_OFS_CHARGE = 8'h06;
	localparam logic [7:0] HPC_OFS_REMOVABLE = 8'h07;
	localparam logic [7:0] HPC_OFS_PORT_USED = 8'h08;
	localparam logic [7:0] HPC_OFS_LEGACY = 8'h0C;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int HPC_BIT_TIMEOUT_FORCE = 1;
	localparam int HPC_BIT_UNLOCK = 7;
	localparam int HPC_FIELD_LSB = 0;
	localparam int HPC_FIELD_MSB = 3;

	// ****************************************
	// Reset values and constants
	// ****************************************
	localparam logic HPC_TIMEOUT_FORCE_RST = 1'h0;
	localparam logic [3:0] HPC_CHARGE_RST = 4'h0;
	localparam logic HPC_UNLOCK_RST = 1'h0;
	localparam logic [3:0] HPC_REMOVABLE_RST = 4'h0;
	localparam logic [3:0] HPC_PORT_USED_RST = 4'hF;
	localparam logic [3:0] HPC_LEGACY_RST = 4'h0;
	localparam logic [7:0] HPC_TIMEOUT_MAX = 8'hFF;
	localparam logic [7:0] HPC_TIMEOUT_OFF = 8'h00;
	localparam logic [7:0] HPC_READ_ZERO = 8'h00;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hpc_cfg_req_type;

	typedef struct packed {
		logic [7:0] u1;
		logic [7:0] u2;
	} hpc_timeout_type;

	typedef struct packed {
		logic init_pending;
		logic timeout_force;
		logic [3:0] charge_en;
		logic unlock;
		logic [3:0] removable;
		logic [3:0] used;
		logic [3:0] legacy;
		logic [7:0] rdata;
		logic rd_ack;
		logic [3:0] removable_out;
		logic [3:0] port_on;
		logic [3:0] legacy_out;
		hpc_timeout_type [3:0] applied;
	} hpc_state_type;

endpackage : hpc_pkg

`default_nettype wire

// ==== verilog/hpc_timeout_map.sv ====
// Substitution of one host-programmed link inactivity timeout.
// Assumes the force level comes from a register of the caller.
`default_nettype none

module hpc_timeout_map
	import hpc_pkg::*;
(
	// Control
	input wire logic force_max,
	// Timeout
	input wire logic [7:0] host_value,
	output logic [7:0] applied_value
);

	// ****************************************
	// Mapping
	// ****************************************
	always_comb begin
		if (force_max && (host_value != HPC_TIMEOUT_OFF)) begin
			applied_value = HPC_TIMEOUT_MAX;
		end else begin
			applied_value = host_value;
		end
	end

endmodule : hpc_timeout_map

`default_nettype wire

// ==== verilog/hpc_lock_view.sv ====
// Visible value of a lockable four-bit port field.
// Assumes the one-time-programmable source is stable while locked.
`default_nettype none

module hpc_lock_view
	import hpc_pkg::*;
#(
	parameter bit INVERT = 1'b0
)
(
	// Control
	input wire logic unlock,
	// Sources
	input wire logic [3:0] stored,
	input wire logic [3:0] otp,
	// Result
	output logic [3:0] view
);

	// ****************************************
	// Selection
	// ****************************************
	always_comb begin
		if (unlock) begin
			view = stored;
		end else if (INVERT) begin
			view = ~otp;
		end else begin
			view = otp;
		end
	end

endmodule : hpc_lock_view

`default_nettype wire

// ==== verilog/hpc_port_config.sv ====
// Configuration registers of a four-port hub: timeout force, charging, removable, port use.
// Assumes register writes come from the EEPROM loader or SMBus slave, one per cycle.
`default_nettype none

// Operation
// - While the timeout force bit is set, host-programmed U1/U2 timeouts are substituted.
// - Under force, any timeout from 1h to FFh is applied as FFh and zero stays zero.
// - Bit 0 of the link power register is reserved and always reads zero.
// - Bits 7:4 of the charging register and bits 6:4 of the removable register read zero.
// - Each charging enable bit switches the charging features of its port on at 1, off at 0.
// - Charging enable bit n belongs to downstream port n+1.
// - At reset release the four power switch and charge straps load the charging field.
// - In serial configuration mode the charging field may be overwritten by EEPROM or SMBus.
// - While unlock is 0 the removable, port-used and legacy fields are read only from OTP.
// - While unlock is 1 those three fields are writable by EEPROM or SMBus.
// - One write that sets unlock also stores the removable bits it carries.
// - A removable bit reads 1 for a removable device and 0 for a fixed one.
// - Removable bit n belongs to downstream port n+1.
// - While locked each removable bit reads as the inverse of the OTP non-removable bit.
// - Each port-used bit enables its port at 1 and disables it at 0 unless its legacy bit is set, bit n for port n+1.
// - A set legacy-speed-only bit keeps that port enabled whatever its port-used bit.
module hpc_port_config
	import hpc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire hpc_cfg_req_type cfg_req,
	output logic [7:0] cfg_rdata,
	output logic cfg_rd_ack,
	// Configuration sources
	input wire logic cfg_serial_mode,
	input wire logic [3:0] power_switch_charge_straps,
	input wire logic [3:0] otp_non_removable,
	input wire logic [3:0] otp_used,
	input wire logic [3:0] otp_legacy,
	// Host-programmed timeouts
	input wire hpc_timeout_type [3:0] host_timeout,
	output hpc_timeout_type [3:0] applied_timeout,
	// Port controls
	output logic lpm_timeout_force,
	output logic [3:0] charge_port_enable,
	output logic removable_override_unlock,
	output logic [3:0] device_removable,
	output logic [3:0] port_enabled,
	output logic [3:0] legacy_speed_only_port
);

	// ****************************************
	// State
	// ****************************************
	hpc_state_type st;
	hpc_state_type next_st;
	logic [3:0] removable_view;
	logic [3:0] used_view;
	logic [3:0] legacy_view;
	logic [3:0][7:0] mapped_u1;
	logic [3:0][7:0] mapped_u2;
	logic wr_link;
	logic wr_charge;
	logic wr_removable;
	logic wr_used;
	logic wr_legacy;

	// ****************************************
	// Decode
	// ****************************************
	assign wr_link = cfg_req.wr && (cfg_req.addr == HPC_OFS_LINK_POWER);
	assign wr_charge = cfg_req.wr && (cfg_req.addr == HPC_OFS_CHARGE);
	assign wr_removable = cfg_req.wr && (cfg_req.addr == HPC_OFS_REMOVABLE);
	assign wr_used = cfg_req.wr && (cfg_req.addr == HPC_OFS_PORT_USED);
	assign wr_legacy = cfg_req.wr && (cfg_req.addr == HPC_OFS_LEGACY);

	// ****************************************
	// Lockable field views
	// ****************************************
	hpc_lock_view #(
		.INVERT(1'b1)
	) u_removable_view (
		.unlock(st.unlock),
		.stored(st.removable),
		.otp(otp_non_removable),
		.view(removable_view)
	);

	hpc_lock_view #(
		.INVERT(1'b0)
	) u_used_view (
		.unlock(st.unlock),
		.stored(st.used),
		.otp(otp_used),
		.view(used_view)
	);

	hpc_lock_view #(
		.INVERT(1'b0)
	) u_legacy_view (
		.unlock(st.unlock),
		.stored(st.legacy),
		.otp(otp_legacy),
		.view(legacy_view)
	);

	// ****************************************
	// Timeout substitution, one pair per port
	// ****************************************
	for (genvar p = 0; p < 4; p++) begin : g_port
		hpc_timeout_map u_map_u1 (
			.force_max(st.timeout_force),
			.host_value(host_timeout[p].u1),
			.applied_value(mapped_u1[p])
		);
		hpc_timeout_map u_map_u2 (
			.force_max(st.timeout_force),
			.host_value(host_timeout[p].u2),
			.applied_value(mapped_u2[p])
		);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st = st;
		// Straps win over a write in the first cycle after reset, so the default is never lost
		if (st.init_pending) begin
			next_st.charge_en = power_switch_charge_straps;
			next_st.init_pending = 1'b0;
		end else if (wr_charge && cfg_serial_mode) begin
			next_st.charge_en = cfg_req.wdata[HPC_FIELD_MSB:HPC_FIELD_LSB];
		end
		if (wr_link) begin
			next_st.timeout_force = cfg_req.wdata[HPC_BIT_TIMEOUT_FORCE];
		end
		if (wr_removable) begin
			next_st.unlock = cfg_req.wdata[HPC_BIT_UNLOCK];
			// The new unlock value gates the field, so one write opens and loads it
			if (cfg_req.wdata[HPC_BIT_UNLOCK]) begin
				next_st.removable = cfg_req.wdata[HPC_FIELD_MSB:HPC_FIELD_LSB];
			end
		end
		if (wr_used && st.unlock) begin
			next_st.used = cfg_req.wdata[HPC_FIELD_MSB:HPC_FIELD_LSB];
		end
		if (wr_legacy && st.unlock) begin
			next_st.legacy = cfg_req.wdata[HPC_FIELD_MSB:HPC_FIELD_LSB];
		end
		// Read answer one cycle after the strobe
		next_st.rd_ack = cfg_req.rd;
		next_st.rdata = HPC_READ_ZERO;
		if (cfg_req.rd) begin
			case (cfg_req.addr)
				HPC_OFS_LINK_POWER: begin
					next_st.rdata = {6'h00, st.timeout_force, 1'h0};
				end
				HPC_OFS_CHARGE: begin
					next_st.rdata = {4'h0, st.charge_en};
				end
				HPC_OFS_REMOVABLE: begin
					next_st.rdata = {st.unlock, 3'h0, removable_view};
				end
				HPC_OFS_PORT_USED: begin
					next_st.rdata = {4'h0, used_view};
				end
				HPC_OFS_LEGACY: begin
					next_st.rdata = {4'h0, legacy_view};
				end
				default: begin
					next_st.rdata = HPC_READ_ZERO;
				end
			endcase
		end
		// Port controls, bit n drives downstream port n+1
		next_st.removable_out = removable_view;
		next_st.legacy_out = legacy_view;
		next_st.port_on = used_view | legacy_view;
		for (int p = 0; p < 4; p++) begin
			next_st.applied[p].u1 = mapped_u1[p];
			next_st.applied[p].u2 = mapped_u2[p];
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.init_pending <= 1'b1;
			st.timeout_force <= HPC_TIMEOUT_FORCE_RST;
			st.charge_en <= HPC_CHARGE_RST;
			st.unlock <= HPC_UNLOCK_RST;
			st.removable <= HPC_REMOVABLE_RST;
			st.used <= HPC_PORT_USED_RST;
			st.legacy <= HPC_LEGACY_RST;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign cfg_rdata = st.rdata;
	assign cfg_rd_ack = st.rd_ack;
	assign applied_timeout = st.applied;
	assign lpm_timeout_force = st.timeout_force;
	assign charge_port_enable = st.charge_en;
	assign removable_override_unlock = st.unlock;
	assign device_removable = st.removable_out;
	assign port_enabled = st.port_on;
	assign legacy_speed_only_port = st.legacy_out;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_force_nonzero;
		(lpm_timeout_force && (host_timeout[0].u1 != 8'h00)) |=> (applied_timeout[0].u1 == 8'hFF);
	endproperty
	a_force_nonzero: assert property (p_force_nonzero) else $error("forced timeout not FFh");

	property p_force_zero;
		(lpm_timeout_force && (host_timeout[3].u2 == 8'h00)) |=> (applied_timeout[3].u2 == 8'h00);
	endproperty
	a_force_zero: assert property (p_force_zero) else $error("zero timeout not kept");

	property p_no_force;
		!lpm_timeout_force |=> (applied_timeout[1].u2 == $past(host_timeout[1].u2));
	endproperty
	a_no_force: assert property (p_no_force) else $error("timeout altered without force");

	property p_link_reserved;
		(cfg_req.rd && (cfg_req.addr == 8'h05)) |=> (cfg_rd_ack && (cfg_rdata[0] == 1'b0));
	endproperty
	a_link_reserved: assert property (p_link_reserved) else $error("reserved bit 0 read one");

	property p_charge_reserved;
		(cfg_req.rd && (cfg_req.addr == 8'h06)) |=> (cfg_rdata[7:4] == 4'h0);
	endproperty
	a_charge_reserved: assert property (p_charge_reserved) else $error("charge reserved nonzero");

	property p_removable_reserved;
		(cfg_req.rd && (cfg_req.addr == 8'h07)) |=> (cfg_rdata[6:4] == 3'h0);
	endproperty
	a_removable_reserved: assert property (p_removable_reserved) else $error("rmv reserved nonzero");

	property p_strap_capture;
		($past(rst) && !rst) |=> (charge_port_enable == $past(power_switch_charge_straps));
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("straps not captured");

	property p_charge_write;
		(wr_charge && cfg_serial_mode && !st.init_pending)
			|=> (charge_port_enable == $past(cfg_req.wdata[3:0]));
	endproperty
	a_charge_write: assert property (p_charge_write) else $error("charge write lost");

	property p_charge_refused;
		(wr_charge && !cfg_serial_mode && !st.init_pending) |=> $stable(charge_port_enable);
	endproperty
	a_charge_refused: assert property (p_charge_refused) else $error("charge written outside mode");

	property p_locked_removable;
		!removable_override_unlock |=> (device_removable == ~$past(otp_non_removable));
	endproperty
	a_locked_removable: assert property (p_locked_removable) else $error("locked rmv not OTP");

	property p_unlock_store;
		(wr_removable && cfg_req.wdata[7]) ##1 !wr_removable
			|=> (device_removable == $past(cfg_req.wdata[3:0], 2));
	endproperty
	a_unlock_store: assert property (p_unlock_store) else $error("rmv bits not stored");

	property p_legacy_enabled;
		(legacy_speed_only_port & ~port_enabled) == 4'h0;
	endproperty
	a_legacy_enabled: assert property (p_legacy_enabled) else $error("legacy port disabled");

	property p_locked_used;
		(!removable_override_unlock && wr_used) |=> (st.used == $past(st.used));
	endproperty
	a_locked_used: assert property (p_locked_used) else $error("locked used field written");

	property p_force_write;
		wr_link |=> (lpm_timeout_force == $past(cfg_req.wdata[HPC_BIT_TIMEOUT_FORCE]));
	endproperty
	a_force_write: assert property (p_force_write) else $error("force bit write lost");

	property p_force_other_port;
		(lpm_timeout_force && (host_timeout[2].u2 != HPC_TIMEOUT_OFF))
			|=> (applied_timeout[2].u2 == HPC_TIMEOUT_MAX);
	endproperty
	a_force_other_port: assert property (p_force_other_port) else $error("port 3 not FFh");

	property p_unlocked_used;
		(removable_override_unlock && wr_used)
			|=> (st.used == $past(cfg_req.wdata[HPC_FIELD_MSB:HPC_FIELD_LSB]));
	endproperty
	a_unlocked_used: assert property (p_unlocked_used) else $error("used write lost");

	property p_unlocked_legacy;
		(removable_override_unlock && wr_legacy)
			|=> (st.legacy == $past(cfg_req.wdata[HPC_FIELD_MSB:HPC_FIELD_LSB]));
	endproperty
	a_unlocked_legacy: assert property (p_unlocked_legacy) else $error("legacy write lost");

	property p_locked_legacy;
		(!removable_override_unlock && wr_legacy) |=> (st.legacy == $past(st.legacy));
	endproperty
	a_locked_legacy: assert property (p_locked_legacy) else $error("locked legacy written");

	property p_locked_port_on;
		!removable_override_unlock |=> (port_enabled == ($past(otp_used) | $past(otp_legacy)));
	endproperty
	a_locked_port_on: assert property (p_locked_port_on) else $error("locked port use wrong");

	property p_lock_keeps_removable;
		(wr_removable && !cfg_req.wdata[HPC_BIT_UNLOCK]) |=> (st.removable == $past(st.removable));
	endproperty
	a_lock_keeps_removable: assert property (p_lock_keeps_removable) else $error("rmv changed");

	property p_charge_read;
		(cfg_req.rd && (cfg_req.addr == HPC_OFS_CHARGE))
			|=> (cfg_rdata[HPC_FIELD_MSB:HPC_FIELD_LSB] == $past(charge_port_enable));
	endproperty
	a_charge_read: assert property (p_charge_read) else $error("charge read wrong");

	property p_unlock_read;
		(cfg_req.rd && (cfg_req.addr == HPC_OFS_REMOVABLE))
			|=> (cfg_rdata[HPC_BIT_UNLOCK] == $past(removable_override_unlock));
	endproperty
	a_unlock_read: assert property (p_unlock_read) else $error("unlock read wrong");

	c_force_used: cover property (lpm_timeout_force && (host_timeout[2].u1 != 8'h00));
	c_unlock_write: cover property (wr_removable && cfg_req.wdata[7]);
	c_strap_capture: cover property ($past(rst) && !rst && (power_switch_charge_straps != 4'h0));
	c_read_removable: cover property (cfg_rd_ack && removable_override_unlock);
	c_locked_write: cover property (!removable_override_unlock && wr_used);

endmodule : hpc_port_config

`default_nettype wire

// ==== dv/hpc_smbus_host.sv ====
// Model of the SMBus host that writes and reads the configuration registers.
// Assumes the bench calls one task at a time from procedural code.
`default_nettype none

module hpc_smbus_host
	import hpc_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register port
	output hpc_cfg_req_type cfg_req,
	input wire logic [7:0] cfg_rdata,
	input wire logic cfg_rd_ack,
	// Status
	output logic hang
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cfg_req = '0;
		hang = 1'b0;
	end

	// ****************************************
	// Accesses
	// ****************************************
	// Idle address and data carry the inverse of the last byte, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bit got;
		got = 1'b0;
		d = 8'h00;
		@(posedge clk);
		cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: cfg_req.wdata};
		@(posedge clk);
		cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~cfg_req.wdata};
		for (int i = 0; i < 4 && !got; i++) begin
			@(negedge clk);
			if (cfg_rd_ack === 1'b1) begin
				d = cfg_rdata;
				got = 1'b1;
			end
		end
		if (!got) begin
			hang <= 1'b1;
		end
	endtask : rd

endmodule : hpc_smbus_host

`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench of the hub port configuration registers.
// Assumes the SMBus host model drives the register port.
`default_nettype none

module tb
	import hpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [3:0] STRAPS = 4'hA;
	localparam logic [3:0] OTP_NR = 4'h3;
	localparam logic [3:0] OTP_USED = 4'h9;
	localparam logic [3:0] OTP_LEGACY = 4'h2;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_serial_mode = 1'b0;
	logic [3:0] strap_pins = STRAPS;
	hpc_cfg_req_type cfg_req;
	logic [7:0] cfg_rdata;
	logic cfg_rd_ack;
	hpc_timeout_type [3:0] host_timeout = '0;
	hpc_timeout_type [3:0] applied_timeout;
	logic lpm_timeout_force;
	logic removable_override_unlock;
	logic host_hang;
	logic [3:0] charge_port_enable;
	logic [3:0] device_removable;
	logic [3:0] port_enabled;
	logic [3:0] legacy_speed_only_port;
	int mismatches = 0;
	int n_checks = 0;

	always #5 clk = ~clk;

	// ****************************************
	// Instances
	// ****************************************
	hpc_port_config hpc_port_config_i (
		.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
		.cfg_rd_ack(cfg_rd_ack), .cfg_serial_mode(cfg_serial_mode),
		.power_switch_charge_straps(strap_pins), .otp_non_removable(OTP_NR),
		.otp_used(OTP_USED), .otp_legacy(OTP_LEGACY), .host_timeout(host_timeout),
		.applied_timeout(applied_timeout), .lpm_timeout_force(lpm_timeout_force),
		.charge_port_enable(charge_port_enable),
		.removable_override_unlock(removable_override_unlock),
		.device_removable(device_removable), .port_enabled(port_enabled),
		.legacy_speed_only_port(legacy_speed_only_port)
	);

	hpc_smbus_host hpc_smbus_host_i (
		.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
		.cfg_rd_ack(cfg_rd_ack), .hang(host_hang)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		hpc_smbus_host_i.rd(a, v);
		check($sformatf("read %h", a), v, exp);
	endtask : rchk

	// Views lag their registers by one cycle, so two edges are let pass
	task automatic settle();
		repeat (2) @(negedge clk);
	endtask : settle

	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	always @(posedge host_hang) begin
		mismatches++;
		print_verdict();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		settle();
		@(negedge clk);
		check("charge", {4'h0, charge_port_enable}, {4'h0, STRAPS});
		check("removable", {4'h0, device_removable}, {4'h0, ~OTP_NR});
		check("enabled", {4'h0, port_enabled}, {4'h0, OTP_USED | OTP_LEGACY});
		rchk(HPC_OFS_LINK_POWER, 8'h00);
		rchk(HPC_OFS_CHARGE, {4'h0, STRAPS});
		rchk(HPC_OFS_REMOVABLE, {4'h0, ~OTP_NR});
		rchk(HPC_OFS_PORT_USED, {4'h0, OTP_USED});
		rchk(8'h3F, 8'h00);
	endtask : test_reset

	task automatic test_timeout();
		logic [7:0] vals [5] = '{8'h00, 8'h01, 8'h80, 8'hFE, 8'hFF};
		hpc_smbus_host_i.wr(HPC_OFS_LINK_POWER, 8'hFF);
		settle();
		check("force", {7'h0, lpm_timeout_force}, 8'h01);
		rchk(HPC_OFS_LINK_POWER, 8'h02);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			for (int p = 0; p < 4; p++) begin
				host_timeout[p] <= '{u1: vals[(i + p) % 5], u2: vals[(i + p + 2) % 5]};
			end
			settle();
			for (int p = 0; p < 4; p++) begin
				check("u1", applied_timeout[p].u1, (vals[(i + p) % 5] != 0) ? 8'hFF : 8'h00);
				check("u2", applied_timeout[p].u2, (vals[(i + p + 2) % 5] != 0) ? 8'hFF : 8'h00);
			end
		end
		hpc_smbus_host_i.wr(HPC_OFS_LINK_POWER, 8'h00);
		@(posedge clk);
		host_timeout[2].u1 <= 8'h37;
		settle();
		check("u1 free", applied_timeout[2].u1, 8'h37);
	endtask : test_timeout

	task automatic test_charge();
		hpc_smbus_host_i.wr(HPC_OFS_CHARGE, 8'hF5);
		settle();
		check("charge kept", {4'h0, charge_port_enable}, {4'h0, STRAPS});
		@(posedge clk);
		cfg_serial_mode <= 1'b1;
		hpc_smbus_host_i.wr(HPC_OFS_CHARGE, 8'hF5);
		settle();
		check("charge", {4'h0, charge_port_enable}, 8'h05);
		check("port1 charge", {7'h0, charge_port_enable[0]}, 8'h01);
		rchk(HPC_OFS_CHARGE, 8'h05);
	endtask : test_charge

	task automatic test_lock();
		hpc_smbus_host_i.wr(HPC_OFS_REMOVABLE, 8'h05);
		hpc_smbus_host_i.wr(HPC_OFS_PORT_USED, 8'h03);
		hpc_smbus_host_i.wr(HPC_OFS_LEGACY, 8'h04);
		settle();
		check("removable locked", {4'h0, device_removable}, {4'h0, ~OTP_NR});
		rchk(HPC_OFS_PORT_USED, {4'h0, OTP_USED});
		hpc_smbus_host_i.wr(HPC_OFS_REMOVABLE, 8'hFA);
		settle();
		check("unlock", {7'h0, removable_override_unlock}, 8'h01);
		check("removable", {4'h0, device_removable}, 8'h0A);
		check("port1 removable", {7'h0, device_removable[0]}, 8'h00);
		check("legacy kept", {4'h0, legacy_speed_only_port}, 8'h00);
		rchk(HPC_OFS_REMOVABLE, 8'h8A);
		hpc_smbus_host_i.wr(HPC_OFS_PORT_USED, 8'hF3);
		hpc_smbus_host_i.wr(HPC_OFS_LEGACY, 8'h04);
		settle();
		rchk(HPC_OFS_PORT_USED, 8'h03);
		check("enabled", {4'h0, port_enabled}, 8'h07);
		check("legacy", {4'h0, legacy_speed_only_port}, 8'h04);
		hpc_smbus_host_i.wr(HPC_OFS_REMOVABLE, 8'h00);
		settle();
		check("relocked", {4'h0, device_removable}, {4'h0, ~OTP_NR});
		check("enabled locked", {4'h0, port_enabled}, {4'h0, OTP_USED | OTP_LEGACY});
	endtask : test_lock

	// Second reset in mid-run with new strap levels, after force and unlock were set
	task automatic test_rereset();
		hpc_smbus_host_i.wr(HPC_OFS_LINK_POWER, 8'h02);
		hpc_smbus_host_i.wr(HPC_OFS_REMOVABLE, 8'h80);
		@(posedge clk);
		strap_pins <= 4'h6;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle();
		check("charge rst", {4'h0, charge_port_enable}, 8'h06);
		check("force rst", {7'h0, lpm_timeout_force}, 8'h00);
		check("unlock rst", {7'h0, removable_override_unlock}, 8'h00);
		check("removable rst", {4'h0, device_removable}, {4'h0, ~OTP_NR});
		rchk(HPC_OFS_CHARGE, 8'h06);
		rchk(HPC_OFS_LINK_POWER, 8'h00);
	endtask : test_rereset

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		test_timeout();
		test_charge();
		test_lock();
		test_rereset();
		print_verdict();
	end

endmodule : tb

`default_nettype wire
